//--- core/ring_media_pkg.sv
package ring_media_pkg;
	// Register byte offsets
	localparam logic [11:0] ctrl_off     = 12'h000;
	localparam logic [11:0] status_off   = 12'h004;
	localparam logic [11:0] irq_stat_off = 12'h008;
	localparam logic [11:0] irq_mask_off = 12'h00C;
	localparam logic [11:0] tx_data_off  = 12'h010;
	localparam logic [11:0] rx_data_off  = 12'h014;
	localparam logic [11:0] ins_div_off  = 12'h018;

	// Control register fields
	localparam int ctrl_freq_acq_bit = 0;
	localparam int ctrl_insert_bit   = 1;
	localparam int ctrl_wrap_n_bit   = 2;
	localparam int ctrl_tx_en_bit    = 3;

	// Status and interrupt fields
	localparam int st_ready_bit    = 0;
	localparam int st_fault_bit    = 1;
	localparam int st_rx_valid_bit = 2;
	localparam int ev_rx_byte_bit  = 0;
	localparam int ev_fault_bit    = 1;
	localparam int ev_ready_bit    = 2;
	localparam int ev_tx_done_bit  = 3;
	localparam int ev_width        = 4;

	// Reset values
	localparam logic [3:0]  ctrl_reset    = 4'h5;
	localparam logic [15:0] ins_div_reset = 16'h00FA;

	localparam int sync_stages = 2;
	localparam int byte_bits   = 8;
endpackage

//--- core/ring_rx_sampler.sv
// Samples receive data on recovered clock rising edges seen by the core clock
module ring_rx_sampler #(
	parameter int width = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             rclk_in,
	input  wire logic             data_in,
	input  wire logic             enable,
	output logic      [width-1:0] word,
	output logic                  word_valid
);
	if (width < 2 || width > 32) begin : g_bad_width
		$error("ring_rx_sampler width out of range");
	end

	typedef struct packed {
		logic [1:0]       clk_sync;
		logic [1:0]       dat_sync;
		logic             clk_last;
		logic [width-1:0] shift;
		logic [5:0]       count;
		logic [width-1:0] word;
		logic             valid;
	} rx_state_t;

	rx_state_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.clk_sync = {s_reg.clk_sync[0], rclk_in};
		s_next.dat_sync = {s_reg.dat_sync[0], data_in};
		s_next.clk_last = s_reg.clk_sync[1];
		s_next.valid = 1'b0;
		if (!enable) begin
			s_next.count = 6'h00;
		end else if (s_reg.clk_sync[1] && !s_reg.clk_last) begin
			s_next.shift = {s_reg.shift[width-2:0], s_reg.dat_sync[1]};
			if (s_reg.count == 6'(width - 1)) begin
				s_next.count = 6'h00;
				s_next.word = {s_reg.shift[width-2:0], s_reg.dat_sync[1]};
				s_next.valid = 1'b1;
			end else begin
				s_next.count = s_reg.count + 6'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign word = s_reg.word;
	assign word_valid = s_reg.valid;

	chk_no_word_idle: assert property (
		@(posedge core_clk) disable iff (rst)
		!enable |=> !word_valid
	) else $error("word emitted while receive disabled");
endmodule

//--- core/ring_media_interface.sv
// Contract
// - Transmit data leaves as complementary pair.
// - Acquisition high frequency, low phase lock.
// - Insert held low with periodic high pulses.
// - Accept receive data only while ready low.
// - Wire fault low means fault detected.
// - Wrap high normal, low loopback.
//
// The implementer's own choices: the APB register port and the address map.
module ring_media_interface #(
	parameter int rx_width = ring_media_pkg::byte_bits
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        ring_ref_clk,
	input  wire logic        ring_rclk,
	input  wire logic        ring_rx_data,
	input  wire logic        rx_energy_ready_n,
	input  wire logic        wire_fault_n,
	output logic             ring_tx_diff_p,
	output logic             ring_tx_diff_n,
	output logic             freq_acq_ctl,
	output logic             insert_ctl,
	output logic             wrap_n
);
	if (rx_width != ring_media_pkg::byte_bits) begin : g_bad_width
		$error("rx_width must be 8");
	end

	localparam int ev_w = ring_media_pkg::ev_width;

	typedef struct packed {
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
		logic            irq;
		logic [3:0]      ctrl;
		logic [15:0]     ins_div;
		logic [15:0]     ins_cnt;
		logic            ins_pulse;
		logic [1:0]      rdy_sync;
		logic [1:0]      flt_sync;
		logic [1:0]      ref_sync;
		logic            ref_last;
		logic [7:0]      tx_shift;
		logic [3:0]      tx_bits;
		logic            tx_bit;
		logic [7:0]      rx_word;
		logic            rx_valid;
		logic [ev_w-1:0] ev;
		logic [ev_w-1:0] mask;
		logic            flt_last;
		logic            rdy_last;
	} state_t;

	state_t r_reg, r_next;
	logic [7:0] rx_word;
	logic       rx_word_valid;
	logic       rx_ready;
	logic       fault;
	logic       apb_take;
	logic       wr_ctrl;

	assign rx_ready = !r_reg.rdy_sync[1];
	assign fault    = !r_reg.flt_sync[1];

	ring_rx_sampler #(
		.width(rx_width)
	) u_rx (
		.core_clk  (core_clk),
		.rst       (rst),
		.rclk_in   (ring_rclk),
		.data_in   (ring_rx_data),
		.enable    (rx_ready),
		.word      (rx_word),
		.word_valid(rx_word_valid)
	);

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	// Access edge of an APB transfer, and the writes that move the control levels
	assign apb_take = psel && penable && !r_reg.pready;
	assign wr_ctrl  = apb_take && pwrite && hit(paddr, ring_media_pkg::ctrl_off);

	always_comb begin
		logic            acc;
		logic            ref_rise;
		logic [ev_w-1:0] set;
		logic [ev_w-1:0] clr;
		acc = 1'b0;
		ref_rise = 1'b0;
		set = '0;
		clr = '0;
		r_next = r_reg;
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;
		r_next.rdy_sync = {r_reg.rdy_sync[0], rx_energy_ready_n};
		r_next.flt_sync = {r_reg.flt_sync[0], wire_fault_n};
		r_next.ref_sync = {r_reg.ref_sync[0], ring_ref_clk};
		r_next.ref_last = r_reg.ref_sync[1];
		r_next.flt_last = fault;
		r_next.rdy_last = rx_ready;
		ref_rise = r_reg.ref_sync[1] && !r_reg.ref_last;

		// Insert pulse generator: one short high pulse per period
		r_next.ins_pulse = 1'b0;
		if (r_reg.ctrl[ring_media_pkg::ctrl_insert_bit]) begin
			// A zero divider must not leave the line stuck high
			if (r_reg.ins_cnt >= r_reg.ins_div && !r_reg.ins_pulse) begin
				r_next.ins_cnt = 16'h0000;
				r_next.ins_pulse = 1'b1;
			end else begin
				r_next.ins_cnt = r_reg.ins_cnt + 16'h0001;
			end
		end else begin
			r_next.ins_cnt = 16'h0000;
		end

		// Transmit serialiser paced by reference clock edges
		if (ref_rise && r_reg.tx_bits != 4'h0) begin
			r_next.tx_bit = r_reg.tx_shift[7];
			r_next.tx_shift = {r_reg.tx_shift[6:0], 1'b0};
			r_next.tx_bits = r_reg.tx_bits - 4'h1;
			if (r_reg.tx_bits == 4'h1) set[ring_media_pkg::ev_tx_done_bit] = 1'b1;
		end

		if (rx_word_valid) begin
			r_next.rx_word = rx_word;
			r_next.rx_valid = 1'b1;
			set[ring_media_pkg::ev_rx_byte_bit] = 1'b1;
		end
		if (fault && !r_reg.flt_last) set[ring_media_pkg::ev_fault_bit] = 1'b1;
		if (rx_ready && !r_reg.rdy_last) set[ring_media_pkg::ev_ready_bit] = 1'b1;

		// APB slave, one wait state
		acc = apb_take;
		if (acc) begin
			r_next.pready = 1'b1;
			r_next.prdata = 32'h0000_0000;
			if (pwrite) begin
				if (hit(paddr, ring_media_pkg::ctrl_off)) r_next.ctrl = pwdata[3:0];
				else if (hit(paddr, ring_media_pkg::irq_stat_off)) clr = pwdata[ev_w-1:0];
				else if (hit(paddr, ring_media_pkg::irq_mask_off)) r_next.mask = pwdata[ev_w-1:0];
				else if (hit(paddr, ring_media_pkg::ins_div_off)) r_next.ins_div = pwdata[15:0];
				else if (hit(paddr, ring_media_pkg::tx_data_off)) begin
					if (r_reg.tx_bits == 4'h0 && r_reg.ctrl[ring_media_pkg::ctrl_tx_en_bit]) begin
						r_next.tx_shift = pwdata[7:0];
						r_next.tx_bits = 4'(ring_media_pkg::byte_bits);
					end else begin
						r_next.pslverr = 1'b1;
					end
				end else if (!hit(paddr, ring_media_pkg::status_off)
						&& !hit(paddr, ring_media_pkg::rx_data_off)) begin
					r_next.pslverr = 1'b1;
				end
			end else begin
				if (hit(paddr, ring_media_pkg::ctrl_off)) r_next.prdata = {28'h0, r_reg.ctrl};
				else if (hit(paddr, ring_media_pkg::status_off))
					r_next.prdata = {24'h0, r_reg.tx_bits != 4'h0, 4'h0,
						r_reg.rx_valid, fault, rx_ready};
				else if (hit(paddr, ring_media_pkg::irq_stat_off))
					r_next.prdata = {28'h0, r_reg.ev};
				else if (hit(paddr, ring_media_pkg::irq_mask_off))
					r_next.prdata = {28'h0, r_reg.mask};
				else if (hit(paddr, ring_media_pkg::ins_div_off))
					r_next.prdata = {16'h0, r_reg.ins_div};
				else if (hit(paddr, ring_media_pkg::rx_data_off)) begin
					r_next.prdata = {24'h0, r_reg.rx_word};
					if (!rx_word_valid) r_next.rx_valid = 1'b0;
				end else r_next.pslverr = 1'b1;
				if (hit(paddr, ring_media_pkg::tx_data_off)) r_next.pslverr = 1'b0;
			end
		end

		// Set wins over a write-one clear in the same cycle
		r_next.ev = (r_reg.ev & ~clr) | set;
		r_next.irq = |(r_next.ev & r_next.mask);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.ctrl <= ring_media_pkg::ctrl_reset;
			r_reg.ins_div <= ring_media_pkg::ins_div_reset;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign irq = r_reg.irq;
	assign ring_tx_diff_p = r_reg.tx_bit;
	assign ring_tx_diff_n = ~r_reg.tx_bit;
	assign freq_acq_ctl = r_reg.ctrl[ring_media_pkg::ctrl_freq_acq_bit];
	assign insert_ctl = r_reg.ins_pulse;
	assign wrap_n = r_reg.ctrl[ring_media_pkg::ctrl_wrap_n_bit];

	// Transmit pair and its pacing
	chk_tx_complement: assert property (
		@(posedge core_clk) disable iff (rst)
		ring_tx_diff_p != ring_tx_diff_n
	) else $error("transmit pair not complementary");
	chk_tx_paced: assert property (
		@(posedge core_clk) disable iff (rst)
		!$stable(ring_tx_diff_p) |-> $past(r_reg.ref_sync[1] && !r_reg.ref_last)
	) else $error("transmit bit moved off a reference edge");
	chk_tx_busy_refused: assert property (
		@(posedge core_clk) disable iff (rst)
		(apb_take && pwrite && hit(paddr, ring_media_pkg::tx_data_off)
			&& r_reg.tx_bits != 4'h0) |=> pslverr
	) else $error("busy transmit write not refused");
	chk_tx_done_event: assert property (
		@(posedge core_clk) disable iff (rst)
		(r_reg.tx_bits == 4'h1 && r_reg.ref_sync[1] && !r_reg.ref_last)
			|=> r_reg.ev[ring_media_pkg::ev_tx_done_bit]
	) else $error("transmit done not flagged");

	// Acquisition and wrap levels move only on a control write
	chk_acq_write: assert property (
		@(posedge core_clk) disable iff (rst)
		wr_ctrl |=> freq_acq_ctl
			== $past(pwdata[ring_media_pkg::ctrl_freq_acq_bit])
	) else $error("acquisition control not taken from write");
	chk_acq_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		!wr_ctrl |=> $stable(freq_acq_ctl)
	) else $error("acquisition control changed without write");
	chk_wrap_write: assert property (
		@(posedge core_clk) disable iff (rst)
		wr_ctrl |=> wrap_n
			== $past(pwdata[ring_media_pkg::ctrl_wrap_n_bit])
	) else $error("wrap select not taken from write");
	chk_wrap_level: assert property (
		@(posedge core_clk) disable iff (rst)
		!wr_ctrl |=> $stable(wrap_n)
	) else $error("wrap changed spontaneously");

	// Insert line: low with single-cycle high pulses
	chk_insert_pulse: assert property (
		@(posedge core_clk) disable iff (rst)
		insert_ctl |=> !insert_ctl
	) else $error("insert pulse longer than one cycle");
	chk_insert_off: assert property (
		@(posedge core_clk) disable iff (rst)
		!r_reg.ctrl[ring_media_pkg::ctrl_insert_bit] |=> !insert_ctl
	) else $error("insert pulse while disabled");
	chk_insert_period: assert property (
		@(posedge core_clk) disable iff (rst)
		(r_reg.ctrl[ring_media_pkg::ctrl_insert_bit] && !r_reg.ins_pulse
			&& r_reg.ins_cnt >= r_reg.ins_div) |=> insert_ctl
	) else $error("insert pulse missing at period end");

	// Wire fault and receive gating
	chk_fault_event: assert property (
		@(posedge core_clk) disable iff (rst)
		(fault && !r_reg.flt_last) |=> r_reg.ev[ring_media_pkg::ev_fault_bit]
	) else $error("wire fault not flagged");
	chk_fault_status: assert property (
		@(posedge core_clk) disable iff (rst)
		(apb_take && !pwrite && hit(paddr, ring_media_pkg::status_off))
			|=> prdata[ring_media_pkg::st_fault_bit] == $past(fault)
	) else $error("fault status bit wrong");
	chk_rx_gated: assert property (
		@(posedge core_clk) disable iff (rst)
		!rx_ready |=> !rx_word_valid
	) else $error("receive accepted while not ready");
	chk_rx_event: assert property (
		@(posedge core_clk) disable iff (rst)
		rx_word_valid |=> r_reg.rx_valid && r_reg.ev[ring_media_pkg::ev_rx_byte_bit]
	) else $error("received byte not flagged");
	chk_ready_event: assert property (
		@(posedge core_clk) disable iff (rst)
		(rx_ready && !r_reg.rdy_last) |=> r_reg.ev[ring_media_pkg::ev_ready_bit]
	) else $error("ready not flagged");
	chk_sync_delay: assert property (
		@(posedge core_clk) disable iff (rst)
		!wire_fault_n ##1 !wire_fault_n ##1 !wire_fault_n |-> fault
	) else $error("fault sync latency wrong");
	chk_ready_sync: assert property (
		@(posedge core_clk) disable iff (rst)
		rx_energy_ready_n ##1 rx_energy_ready_n ##1 rx_energy_ready_n |-> !rx_ready
	) else $error("ready sync latency wrong");

	// Register bus answer
	chk_pready_pulse: assert property (
		@(posedge core_clk) disable iff (rst)
		pready |=> !pready
	) else $error("pready held longer than one cycle");
	chk_err_with_ready: assert property (
		@(posedge core_clk) disable iff (rst)
		pslverr |-> pready
	) else $error("pslverr without pready");
	chk_write_rdata: assert property (
		@(posedge core_clk) disable iff (rst)
		(apb_take && pwrite) |=> prdata == 32'h0000_0000
	) else $error("read data not cleared on write");
	chk_irq_level: assert property (
		@(posedge core_clk) disable iff (rst)
		irq == |(r_reg.ev & r_reg.mask)
	) else $error("interrupt level mismatch");
endmodule

//--- bench/ring_xcvr_model.sv
module ring_xcvr_model (
	input  wire logic ring_tx_diff_p,
	input  wire logic wrap_n,
	output logic      ring_ref_clk,
	output logic      ring_rclk,
	output logic      ring_rx_data,
	output logic      rx_energy_ready_n,
	output logic      wire_fault_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rx_q;
	logic active;
	initial begin
		ring_ref_clk = 1'b0;
		forever #32 ring_ref_clk = ~ring_ref_clk;
	end
	initial begin
		ring_rclk = 1'b0;
		rx_q = 1'b0;
		active = 1'b0;
		rx_energy_ready_n = 1'b1;
		wire_fault_n = 1'b1;
	end
	// Idle data keeps toggling so a stale bit never looks valid
	always #20 if (!active) rx_q = ~rx_q;
	assign ring_rx_data = wrap_n ? rx_q : ring_tx_diff_p;
	task automatic send_byte(input logic [7:0] b, input logic rdy_n);
		active = 1'b1;
		rx_energy_ready_n = rdy_n;
		#40;
		for (int i = 7; i >= 0; i--) begin
			rx_q = b[i];
			#16 ring_rclk = 1'b1;
			#32 ring_rclk = 1'b0;
			#16;
		end
		rx_energy_ready_n = 1'b1;
		active = 1'b0;
	endtask
	// Takes eight transmit bits, one per reference-clock fall, first bit into the MSB
	task automatic capture_byte(output logic [7:0] v);
		v = 8'h00;
		repeat (8) @(negedge ring_ref_clk) v = {v[6:0], ring_tx_diff_p};
	endtask
endmodule

//--- bench/ring_media_interface_tb_top.sv
module ring_media_interface_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, irq, e, prev;
	logic        ring_ref_clk, ring_rclk, ring_rx_data, rx_energy_ready_n, wire_fault_n;
	logic        ring_tx_diff_p, ring_tx_diff_n, freq_acq_ctl, insert_ctl, wrap_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [7:0]  b, txc;
	int          err_count, n_tests, seed, cyc, cnt, dbl;
	ring_media_interface ring_media_interface_i (.core_clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .ring_ref_clk, .ring_rclk,
		.ring_rx_data, .rx_energy_ready_n, .wire_fault_n, .ring_tx_diff_p, .ring_tx_diff_n,
		.freq_acq_ctl, .insert_ctl, .wrap_n);
	ring_xcvr_model ring_xcvr_model_i (.ring_tx_diff_p, .wrap_n, .ring_ref_clk, .ring_rclk,
		.ring_rx_data, .rx_energy_ready_n, .wire_fault_n);
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rv = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			conclude;
		end
	end
	always @(posedge core_clk) if (!rst) chk("pair", {31'h0, ring_tx_diff_p}, {31'h0, ~ring_tx_diff_n});
	initial begin
		seed = 70;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		apb(0, ring_media_pkg::ctrl_off, 0);
		chk("ctrl", rv, 32'h5);
		apb(0, ring_media_pkg::ins_div_off, 0);
		chk("div", rv, 32'hFA);
		for (int i = 0; i < 4; i++) begin
			apb(1, ring_media_pkg::ctrl_off, {29'h0, i[1], 1'b0, i[0]});
			@(posedge core_clk);
			chk("acq", {31'h0, freq_acq_ctl}, {31'h0, i[0]});
			chk("wrap", {31'h0, wrap_n}, {31'h0, i[1]});
		end
		$display("controls done");
		apb(1, ring_media_pkg::ins_div_off, 4);
		for (int k = 0; k < 2; k++) begin
			apb(1, ring_media_pkg::ctrl_off, k ? 32'h4 : 32'h6);
			repeat (2) @(posedge core_clk);
			{cnt, dbl, prev} = '0;
			repeat (100) begin
				@(posedge core_clk);
				cnt += insert_ctl;
				dbl += insert_ctl & prev;
				prev = insert_ctl;
			end
			chk("pulses", cnt, k ? 0 : 20);
			chk("width", dbl, 0);
		end
		$display("insert done");
		apb(1, ring_media_pkg::irq_mask_off, 32'hF);
		for (int j = 0; j < 3; j++) begin
			apb(1, ring_media_pkg::irq_stat_off, 32'hF);
			b = 8'($random(seed));
			ring_xcvr_model_i.send_byte(b, 1'b0);
			repeat (10) @(posedge core_clk);
			chk("irq", {31'h0, irq}, 1);
			apb(0, ring_media_pkg::irq_stat_off, 0);
			chk("rx ev", {31'h0, rv[0]}, 1);
			apb(0, ring_media_pkg::rx_data_off, 0);
			chk("rx", rv, {24'h0, b});
			apb(1, ring_media_pkg::irq_stat_off, 32'hF);
			ring_xcvr_model_i.send_byte(~b, 1'b1);
			repeat (10) @(posedge core_clk);
			chk("noirq", {31'h0, irq}, 0);
			apb(0, ring_media_pkg::rx_data_off, 0);
			chk("kept", rv, {24'h0, b});
		end
		$display("receive done");
		ring_xcvr_model_i.wire_fault_n = 1'b0;
		repeat (6) @(posedge core_clk);
		apb(0, ring_media_pkg::status_off, 0);
		chk("fault", {31'h0, rv[1]}, 1);
		apb(0, ring_media_pkg::irq_stat_off, 0);
		chk("fault ev", {31'h0, rv[1]}, 1);
		ring_xcvr_model_i.wire_fault_n = 1'b1;
		$display("fault done");
		apb(1, ring_media_pkg::ctrl_off, 32'hD);
		apb(1, ring_media_pkg::irq_stat_off, 32'hF);
		b = 8'($random(seed));
		@(negedge ring_ref_clk);
		@(posedge core_clk);
		fork
			ring_xcvr_model_i.capture_byte(txc);
			begin
				apb(1, ring_media_pkg::tx_data_off, {24'h0, b});
				chk("tx ok", {31'h0, e}, 0);
				apb(1, ring_media_pkg::tx_data_off, 32'h5A);
				chk("busy", {31'h0, e}, 1);
			end
		join
		chk("tx bits", {24'h0, txc}, {24'h0, b});
		rv = '0;
		for (int i = 0; i < 100 && !rv[3]; i++) apb(0, ring_media_pkg::irq_stat_off, 0);
		chk("tx done", {31'h0, rv[3]}, 1);
		apb(1, ring_media_pkg::ctrl_off, 32'h5);
		apb(1, ring_media_pkg::tx_data_off, 32'h1);
		chk("tx off", {31'h0, e}, 1);
		apb(0, 12'hFFC, 0);
		chk("unmapped", {31'h0, e}, 1);
		$display("transmit done");
		conclude;
	end
endmodule
